// ### verilog/cpuexs_pkg.sv
package cpuexs_pkg;
  // Exception sources; priority order holds within the end-of-instruction and trap groups, but traps win across them
  typedef enum logic [3:0] {
    CPUEXS_SRC_RESET,
    CPUEXS_SRC_ADDR_ERR,
    CPUEXS_SRC_TRACE,
    CPUEXS_SRC_INTERRUPT,
    CPUEXS_SRC_UNDEF,
    CPUEXS_SRC_DIV_ZERO,
    CPUEXS_SRC_OVF_TRAP,
    CPUEXS_SRC_VEC_TRAP
  } cpuexs_src_t;

  // Minimum-mode vector word addresses; maximum-mode entries are twice these
  localparam logic [15:0] VEC_RESET = 16'h0000;
  localparam logic [15:0] VEC_UNDEF = 16'h0004;
  localparam logic [15:0] VEC_DIV_ZERO = 16'h0006;
  localparam logic [15:0] VEC_OVF_TRAP = 16'h0008;
  localparam logic [15:0] VEC_ADDR_ERR = 16'h0010;
  localparam logic [15:0] VEC_TRACE = 16'h0012;
  localparam logic [15:0] VEC_NMI = 16'h0016;
  localparam logic [15:0] VEC_VEC_TRAP = 16'h0020;

  // Status word field positions
  localparam int SR_TRACE_BIT = 15;
  localparam int SR_MASK_HI = 10;
  localparam int SR_MASK_LO = 8;

  // Reset input filter: two synchroniser stages ahead of the edge detector
  localparam int SYNC_STAGES = 2;
  localparam logic [7:0] CODE_PAGE_ZERO = 8'h00;
endpackage

// ### verilog/cpuexs_sync.sv
`timescale 1ns/100ps
module cpuexs_sync #(
  parameter int STAGES = 2
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic async_in,
  output logic sync_out
);
  logic [STAGES-1:0] stage_r;
  logic [STAGES-1:0] stage_nxt;

  // Each stage reads only its predecessor; the first is never tapped
  always_comb begin
    stage_nxt = {stage_r[STAGES-2:0], async_in};
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      stage_r <= '0;
    end else begin
      stage_r <= stage_nxt;
    end
  end

  assign sync_out = stage_r[STAGES-1];
endmodule // cpuexs_sync

// ### verilog/cpuexs_sequencer.sv
`timescale 1ns/100ps
module cpuexs_sequencer
  import cpuexs_pkg::*;
#(
  parameter int VEC_W = 16
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic reset_input_n,
  input wire logic max_mode,
  input wire logic insn_done,
  input wire logic insn_start,
  input wire logic undef_code,
  input wire logic unsigned_divide_op,
  input wire logic divisor_zero,
  input wire logic overflow_trap_op,
  input wire logic vectored_trap_op,
  input wire logic [3:0] trap_number,
  input wire logic addr_error,
  input wire logic int_req,
  input wire logic [VEC_W-1:0] int_vector,
  input wire logic [15:0] status_word,
  input wire logic [7:0] code_page,
  input wire logic [15:0] program_counter,
  input wire logic mem_ack,
  input wire logic [15:0] mem_rdata,
  output logic core_hold,
  output logic mem_req,
  output logic mem_write,
  output logic [23:0] mem_addr,
  output logic [15:0] mem_wdata,
  output logic stack_push,
  output logic new_pc_valid,
  output logic [15:0] new_pc,
  output logic [7:0] new_cp,
  output logic [15:0] new_sr,
  output logic int_ack,
  output logic [3:0] active_src
);
  typedef enum logic [2:0] {
    ST_RESET, ST_RUN, ST_PUSH_PC, ST_PUSH_SR, ST_PUSH_CP, ST_VEC_HI, ST_VEC_LO
  } cpuexs_state_t;

  cpuexs_state_t state_r, state_nxt;
  cpuexs_src_t src_r, src_nxt;
  logic [15:0] vec_addr_r, vec_addr_nxt;
  logic [15:0] sr_r, sr_nxt;
  logic [15:0] pc_r, pc_nxt;
  logic [7:0] cp_r, cp_nxt;
  logic first_insn_r, first_insn_nxt;
  logic ae_pend_r, ae_pend_nxt;
  logic res_sync;
  logic res_prev_r;
  logic core_hold_nxt, mem_req_nxt, mem_write_nxt, stack_push_nxt;
  logic new_pc_valid_nxt, int_ack_nxt;
  logic [23:0] mem_addr_nxt;
  logic [15:0] mem_wdata_nxt, new_pc_nxt, new_sr_nxt;
  logic [7:0] new_cp_nxt;

  cpuexs_sync #(.STAGES(SYNC_STAGES)) u_res_sync (
    .clk_sys(clk_sys),
    .rst(rst),
    .async_in(reset_input_n),
    .sync_out(res_sync)
  );

  // Vector byte address: entry width doubles in maximum mode, always in page zero
  function automatic logic [23:0] vec_byte_addr(input logic [15:0] base, input logic maxm);
    vec_byte_addr = maxm ? {CODE_PAGE_ZERO, base[14:0], 1'b0}
                         : {CODE_PAGE_ZERO, base};
  endfunction

  always_comb begin
    state_nxt = state_r;
    src_nxt = src_r;
    vec_addr_nxt = vec_addr_r;
    sr_nxt = sr_r;
    pc_nxt = pc_r;
    cp_nxt = cp_r;
    first_insn_nxt = first_insn_r;
    ae_pend_nxt = ae_pend_r | addr_error;
    core_hold_nxt = 1'b1;
    mem_req_nxt = 1'b0;
    mem_write_nxt = 1'b0;
    mem_addr_nxt = mem_addr;
    mem_wdata_nxt = mem_wdata;
    stack_push_nxt = 1'b0;
    new_pc_valid_nxt = 1'b0;
    new_pc_nxt = new_pc;
    new_cp_nxt = new_cp;
    new_sr_nxt = new_sr;
    int_ack_nxt = 1'b0;
    if (!res_sync) begin
      // Held low: everything stops and sequencer state is cleared
      state_nxt = ST_RESET;
      first_insn_nxt = 1'b1;
      ae_pend_nxt = 1'b0;
    end else begin
      unique case (state_r)
        ST_RESET: begin
          if (!res_prev_r) begin
            // Rising edge of the reset input launches the reset vector fetch
            src_nxt = CPUEXS_SRC_RESET;
            vec_addr_nxt = VEC_RESET;
            sr_nxt = status_word;
            state_nxt = max_mode ? ST_VEC_HI : ST_VEC_LO;
            mem_req_nxt = 1'b1;
            mem_addr_nxt = vec_byte_addr(VEC_RESET, max_mode);
          end
        end
        ST_RUN: begin
          core_hold_nxt = 1'b0;
          sr_nxt = status_word;
          pc_nxt = program_counter;
          cp_nxt = code_page;
          if (insn_start && (undef_code || (unsigned_divide_op && divisor_zero) ||
              overflow_trap_op || vectored_trap_op)) begin
            // At most one of these is ever active, so a plain ladder suffices
            if (undef_code) begin
              src_nxt = CPUEXS_SRC_UNDEF;
              vec_addr_nxt = VEC_UNDEF;
            end else if (unsigned_divide_op && divisor_zero) begin
              src_nxt = CPUEXS_SRC_DIV_ZERO;
              vec_addr_nxt = VEC_DIV_ZERO;
            end else if (overflow_trap_op) begin
              src_nxt = CPUEXS_SRC_OVF_TRAP;
              vec_addr_nxt = VEC_OVF_TRAP;
            end else begin
              src_nxt = CPUEXS_SRC_VEC_TRAP;
              vec_addr_nxt = VEC_VEC_TRAP + {11'h000, trap_number, 1'b0};
            end
            state_nxt = ST_PUSH_PC;
            core_hold_nxt = 1'b1;
          end else if (insn_done && (ae_pend_r || addr_error)) begin
            src_nxt = CPUEXS_SRC_ADDR_ERR;
            vec_addr_nxt = VEC_ADDR_ERR;
            ae_pend_nxt = 1'b0;
            first_insn_nxt = 1'b0;
            state_nxt = ST_PUSH_PC;
            core_hold_nxt = 1'b1;
          end else if (insn_done && status_word[SR_TRACE_BIT]) begin
            src_nxt = CPUEXS_SRC_TRACE;
            vec_addr_nxt = VEC_TRACE;
            first_insn_nxt = 1'b0;
            state_nxt = ST_PUSH_PC;
            core_hold_nxt = 1'b1;
          end else if (insn_done && int_req && !first_insn_r) begin
            src_nxt = CPUEXS_SRC_INTERRUPT;
            vec_addr_nxt = 16'(int_vector);
            int_ack_nxt = 1'b1;
            state_nxt = ST_PUSH_PC;
            core_hold_nxt = 1'b1;
          end else if (insn_done) begin
            first_insn_nxt = 1'b0;
          end
        end
        ST_PUSH_PC: begin
          stack_push_nxt = 1'b1;
          mem_write_nxt = 1'b1;
          mem_req_nxt = 1'b1;
          mem_wdata_nxt = pc_r;
          state_nxt = ST_PUSH_SR;
        end
        ST_PUSH_SR: begin
          if (mem_ack) begin
            stack_push_nxt = 1'b1;
            mem_write_nxt = 1'b1;
            mem_req_nxt = 1'b1;
            mem_wdata_nxt = sr_r;
            state_nxt = max_mode ? ST_PUSH_CP : ST_VEC_HI;
          end else begin
            mem_req_nxt = mem_req;
            mem_write_nxt = mem_write;
          end
        end
        ST_PUSH_CP: begin
          if (mem_ack) begin
            stack_push_nxt = 1'b1;
            mem_write_nxt = 1'b1;
            mem_req_nxt = 1'b1;
            mem_wdata_nxt = {8'h00, cp_r};
            state_nxt = ST_VEC_HI;
          end else begin
            mem_req_nxt = mem_req;
            mem_write_nxt = mem_write;
          end
        end
        ST_VEC_HI: begin
          // First vector word: page byte in maximum mode, its upper byte discarded
          if (mem_ack || (src_r == CPUEXS_SRC_RESET && !mem_req)) begin
            if (src_r != CPUEXS_SRC_RESET && !max_mode) begin
              mem_req_nxt = 1'b1;
              mem_addr_nxt = vec_byte_addr(vec_addr_r, 1'b0);
              state_nxt = ST_VEC_LO;
            end else begin
              if (src_r == CPUEXS_SRC_RESET && !mem_req) begin
                mem_req_nxt = 1'b1;
                mem_addr_nxt = vec_byte_addr(vec_addr_r, 1'b1);
              end else if (mem_write) begin
                mem_req_nxt = 1'b1;
                mem_addr_nxt = vec_byte_addr(vec_addr_r, 1'b1);
              end else begin
                new_cp_nxt = mem_rdata[7:0];
                mem_req_nxt = 1'b1;
                mem_addr_nxt = vec_byte_addr(vec_addr_r, 1'b1) + 24'h000002;
                state_nxt = ST_VEC_LO;
              end
            end
          end else begin
            mem_req_nxt = mem_req;
            mem_write_nxt = mem_write;
          end
        end
        ST_VEC_LO: begin
          if (mem_ack) begin
            new_pc_nxt = mem_rdata;
            if (!max_mode) begin
              new_cp_nxt = code_page;
            end
            // Trace flag cleared, mask level kept as it was
            new_sr_nxt = sr_r;
            new_sr_nxt[SR_TRACE_BIT] = 1'b0;
            new_pc_valid_nxt = 1'b1;
            state_nxt = ST_RUN;
          end else begin
            mem_req_nxt = mem_req;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_r <= ST_RESET;
      src_r <= CPUEXS_SRC_RESET;
      vec_addr_r <= 16'h0000;
      sr_r <= 16'h0000;
      pc_r <= 16'h0000;
      cp_r <= 8'h00;
      first_insn_r <= 1'b1;
      ae_pend_r <= 1'b0;
      res_prev_r <= 1'b0;
      core_hold <= 1'b1;
      mem_req <= 1'b0;
      mem_write <= 1'b0;
      mem_addr <= 24'h000000;
      mem_wdata <= 16'h0000;
      stack_push <= 1'b0;
      new_pc_valid <= 1'b0;
      new_pc <= 16'h0000;
      new_cp <= 8'h00;
      new_sr <= 16'h0000;
      int_ack <= 1'b0;
      active_src <= 4'h0;
    end else begin
      state_r <= state_nxt;
      src_r <= src_nxt;
      vec_addr_r <= vec_addr_nxt;
      sr_r <= sr_nxt;
      pc_r <= pc_nxt;
      cp_r <= cp_nxt;
      first_insn_r <= first_insn_nxt;
      ae_pend_r <= ae_pend_nxt;
      res_prev_r <= res_sync;
      core_hold <= core_hold_nxt;
      mem_req <= mem_req_nxt;
      mem_write <= mem_write_nxt;
      mem_addr <= mem_addr_nxt;
      mem_wdata <= mem_wdata_nxt;
      stack_push <= stack_push_nxt;
      new_pc_valid <= new_pc_valid_nxt;
      new_pc <= new_pc_nxt;
      new_cp <= new_cp_nxt;
      new_sr <= new_sr_nxt;
      int_ack <= int_ack_nxt;
      active_src <= src_nxt;
    end
  end
endmodule // cpuexs_sequencer

// ### tb/cpuexs_sequencer_assertions.sv
`timescale 1ns/100ps
module cpuexs_sequencer_checker
  import cpuexs_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic reset_input_n,
  input wire logic insn_done,
  input wire logic [15:0] status_word,
  input wire logic core_hold,
  input wire logic mem_req,
  input wire logic mem_ack,
  input wire logic mem_write,
  input wire logic [23:0] mem_addr,
  input wire logic stack_push,
  input wire logic new_pc_valid,
  input wire logic [15:0] new_sr,
  input wire logic int_ack,
  input wire logic [3:0] active_src
);
  logic fresh_r;

  // Set by the reset vector load, cleared by the first completed instruction
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      fresh_r <= 1'b0;
    end else if (new_pc_valid && active_src == CPUEXS_SRC_RESET) begin
      fresh_r <= 1'b1;
    end else if (insn_done) begin
      fresh_r <= 1'b0;
    end
  end

  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  // Two synchroniser flops plus the core_hold output register
  chk_hold_reset: assert property (!reset_input_n [*4] |=> core_hold)
    else $error("core runs while reset pin low");
  chk_req_held: assert property (reset_input_n && mem_req && !mem_ack
    |=> mem_req && $stable(mem_addr) && $stable(mem_write)) else $error("request dropped");
  chk_vec_page0: assert property (mem_req && !mem_write
    |-> mem_addr[23:16] == 8'h00 && !mem_addr[0]) else $error("bad vector address");
  chk_push_write: assert property (stack_push |-> mem_req && mem_write)
    else $error("push without write");
  chk_reset_reads: assert property (mem_req && active_src == CPUEXS_SRC_RESET
    |-> !mem_write) else $error("write in reset sequence");
  chk_trace_clr: assert property (new_pc_valid && active_src != CPUEXS_SRC_RESET
    |-> !new_sr[SR_TRACE_BIT]) else $error("trace flag kept");
  chk_mask_kept: assert property (new_pc_valid && active_src == CPUEXS_SRC_ADDR_ERR
    |-> new_sr[10:8] == status_word[10:8]) else $error("mask changed");
  chk_int_block: assert property (new_pc_valid && active_src == CPUEXS_SRC_RESET
    |=> !int_ack [*8]) else $error("interrupt right after reset");
  chk_first_insn: assert property (fresh_r && insn_done |=> !int_ack)
    else $error("interrupt taken at first instruction");
endmodule // cpuexs_sequencer_checker

bind cpuexs_sequencer cpuexs_sequencer_checker u_chk (.clk_sys, .rst, .reset_input_n, .insn_done,
  .status_word, .core_hold, .mem_req, .mem_ack, .mem_write, .mem_addr, .stack_push,
  .new_pc_valid, .new_sr, .int_ack, .active_src);

// ### tb/cpuexs_mem_model.sv
`timescale 1ns/100ps
module cpuexs_mem_model (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic mem_req,
  input wire logic [23:0] mem_addr,
  input wire logic [3:0] wait_n,
  output logic mem_ack,
  output logic [15:0] mem_rdata
);
  logic [3:0] cnt_r;
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cnt_r <= 4'h0;
      mem_ack <= 1'b0;
      mem_rdata <= 16'h0;
    end else begin
      mem_ack <= 1'b0;
      // Data is only valid with the acknowledge, so it never looks held
      mem_rdata <= ~mem_rdata;
      if (mem_req && !mem_ack) begin
        // A count left over from a cut cycle must not push the answer past the wait
        cnt_r <= (cnt_r >= wait_n) ? 4'h0 : cnt_r + 4'h1;
        if (cnt_r >= wait_n) begin
          mem_ack <= 1'b1;
          mem_rdata <= mem_addr[15:0] + 16'h1000;
        end
      end
    end
  end
endmodule // cpuexs_mem_model

// ### tb/cpuexs_sequencer_test.sv
`timescale 1ns/100ps
module cpuexs_sequencer_test
  import cpuexs_pkg::*;
();
  logic clk_sys, rst, reset_input_n, max_mode, insn_done, insn_start, undef_code, addr_error;
  logic unsigned_divide_op, divisor_zero, overflow_trap_op, vectored_trap_op, int_req, mem_ack;
  logic core_hold, mem_req, mem_write, stack_push, new_pc_valid, int_ack;
  logic [3:0] trap_number, active_src, wait_n;
  logic [15:0] int_vector, status_word, program_counter, mem_rdata, mem_wdata, new_pc, new_sr;
  logic [7:0] code_page, new_cp;
  logic [23:0] mem_addr;
  logic [15:0] wq[$];
  logic [23:0] rq[$];
  int bad_count = 0;
  int tests_run = 0;
  int acks = 0;

  cpuexs_sequencer dut (.clk_sys, .rst, .reset_input_n, .max_mode, .insn_done, .insn_start,
    .undef_code, .unsigned_divide_op, .divisor_zero, .overflow_trap_op, .vectored_trap_op,
    .trap_number, .addr_error, .int_req, .int_vector, .status_word, .code_page,
    .program_counter, .mem_ack, .mem_rdata, .core_hold, .mem_req, .mem_write, .mem_addr,
    .mem_wdata, .stack_push, .new_pc_valid, .new_pc, .new_cp, .new_sr, .int_ack, .active_src);
  cpuexs_mem_model mem (.clk_sys, .rst, .mem_req, .mem_addr, .wait_n, .mem_ack, .mem_rdata);

  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  // Records every completed memory cycle and every interrupt acceptance
  always @(posedge clk_sys) begin
    if (mem_req === 1'b1 && mem_ack === 1'b1) begin
      if (mem_write) wq.push_back(mem_wdata);
      else rq.push_back(mem_addr);
    end
    if (int_ack === 1'b1) begin
      acks++;
    end
  end

  task automatic chk(input logic ok, input string msg);
    tests_run++;
    if (ok !== 1'b1) begin
      bad_count++;
      $display("CHECK FAILED at %0t: %s", $time, msg);
    end
  endtask

  task automatic summarize();
    if (bad_count == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic done_pulse();
    insn_done = 1'b1;
    @(negedge clk_sys);
    insn_done = 1'b0;
  endtask

  task automatic expect_seq(input int np, input logic [15:0] va, input logic [3:0] src);
    int n;
    logic [15:0] v;
    n = 0;
    v = va << max_mode;
    while (new_pc_valid !== 1'b1 && n < 400) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    chk(n < 400 && wq.size() == np && rq.size() == max_mode + 1, "count");
    chk(rq[0] === {8'h00, v} && active_src === src, "vector");
    chk(new_pc === v + (max_mode ? 16'h1002 : 16'h1000), "pc");
    if (max_mode) chk(rq[1] === {8'h00, v + 16'h2} && new_cp === v[7:0], "page");
    if (np > 1) chk(wq[0] === program_counter && wq[1] === status_word, "push");
    if (np > 1) chk(!new_sr[15] && new_sr[10:8] === status_word[10:8], "sr");
    if (np > 2) chk(wq[2][7:0] === code_page, "cp push");
    wq.delete();
    rq.delete();
    @(negedge clk_sys);
  endtask

  task automatic t_reset(input logic mm);
    int a;
    a = acks;
    reset_input_n = 1'b0;
    max_mode = mm;
    wait_n = mm ? 4'h3 : 4'h0;
    repeat (8) @(negedge clk_sys);
    chk(core_hold === 1'b1, "no hold");
    wq.delete();
    rq.delete();
    int_req = 1'b1;
    reset_input_n = 1'b1;
    expect_seq(0, VEC_RESET, CPUEXS_SRC_RESET);
    repeat (10) @(negedge clk_sys);
    chk(acks == a, "early interrupt");
    // First instruction stands for the stack set-up that must precede any interrupt
    done_pulse();
    chk(int_ack === 1'b0 && core_hold === 1'b0, "interrupt on first instruction");
    done_pulse();
    int_req = 1'b0;
    expect_seq(2 + mm, 16'h0040, CPUEXS_SRC_INTERRUPT);
    chk(acks == a + 1, "no ack");
  endtask

  task automatic t_trace();
    status_word = 16'h8500;
    repeat (2) begin
      done_pulse();
      expect_seq(2 + max_mode, VEC_TRACE, CPUEXS_SRC_TRACE);
    end
    status_word = 16'h0500;
  endtask

  task automatic t_insn();
    logic [15:0] vt[4];
    logic [3:0] st[4];
    vt = '{VEC_UNDEF, VEC_DIV_ZERO, VEC_OVF_TRAP, VEC_VEC_TRAP + 16'h001e};
    st = '{CPUEXS_SRC_UNDEF, CPUEXS_SRC_DIV_ZERO, CPUEXS_SRC_OVF_TRAP, CPUEXS_SRC_VEC_TRAP};
    unsigned_divide_op = 1'b1;
    divisor_zero = 1'b0;
    insn_start = 1'b1;
    @(negedge clk_sys);
    insn_start = 1'b0;
    chk(core_hold === 1'b0 && stack_push === 1'b0, "divide by nonzero trapped");
    for (int i = 0; i < 4; i++) begin
      {undef_code, unsigned_divide_op, overflow_trap_op, vectored_trap_op} = 4'h8 >> i;
      divisor_zero = (i == 1);
      insn_start = 1'b1;
      @(negedge clk_sys);
      insn_start = 1'b0;
      expect_seq(2, vt[i], st[i]);
    end
    {undef_code, unsigned_divide_op, overflow_trap_op, vectored_trap_op, divisor_zero} = 5'h00;
  endtask

  task automatic t_prio();
    int a;
    a = acks;
    status_word = 16'h8500;
    addr_error = 1'b1;
    @(negedge clk_sys);
    addr_error = 1'b0;
    int_req = 1'b1;
    done_pulse();
    expect_seq(2, VEC_ADDR_ERR, CPUEXS_SRC_ADDR_ERR);
    // The losers wait their turn: trace next, the interrupt last
    done_pulse();
    expect_seq(2, VEC_TRACE, CPUEXS_SRC_TRACE);
    status_word = 16'h0500;
    done_pulse();
    int_req = 1'b0;
    expect_seq(2, 16'h0040, CPUEXS_SRC_INTERRUPT);
    chk(acks == a + 1, "lost interrupt");
  endtask

  initial begin
    {reset_input_n, max_mode, insn_done, insn_start, undef_code, unsigned_divide_op,
      divisor_zero, overflow_trap_op, vectored_trap_op, addr_error, int_req} = '0;
    rst = 1'b1;
    wait_n = 4'h0;
    trap_number = 4'hf;
    int_vector = 16'h0040;
    status_word = 16'h0500;
    program_counter = 16'h2222;
    code_page = 8'h05;
    repeat (16) @(negedge clk_sys);
    rst = 1'b0;
    t_reset(1'b0);
    t_trace();
    t_insn();
    t_prio();
    t_reset(1'b1);
    t_trace();
    summarize();
  end

  initial begin
    #200000;
    bad_count++;
    summarize();
  end
endmodule // cpuexs_sequencer_test
